// *** rtl/power_saving_mode_control.sv ***
// module: power-mode controller with power control register on APB
`timescale 1ns/1ps

module power_saving_mode_control
  import pwr_mode_pkg::*;
#(
  parameter int NUM_IRQ   = 7,
  parameter int HOLD_CLKS = EXT_RST_CLKS
) (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // system side
  input  wire logic [NUM_IRQ-1:0] irq_pending,
  input  wire logic               ext_reset_req,
  input  wire logic               low_voltage_detect,
  input  wire logic               watchdog_reset,
  output logic                    cpu_clk_en,
  output logic                    periph_clk_en,
  output logic                    osc_enable,
  output logic                    core_reset,
  output logic                    low_voltage_reset,
  output periph_cfg_t             periph_cfg,
  output pwr_mode_t               mode
);

  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 7) $error("NUM_IRQ must be 1..7");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] power_control_q;
  logic [7:0] irq_enable_q;
  pwr_mode_t  mode_q;
  pwr_mode_t  mode_d;
  logic       core_reset_q;
  logic       lvr_q;

  logic       wr_en;
  logic       rd_en;
  logic       hit_pc;
  logic       hit_ie;
  logic       hit_st;
  logic       wake_irq;
  logic       ext_taken;
  logic       int_reset;
  logic       any_reset;
  logic       restart_busy;
  logic       restart_done;
  logic       restart_start;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  always_comb begin
    hit_pc = 1'b0;
    hit_ie = 1'b0;
    hit_st = 1'b0;
    if (paddr == POWER_CONTROL_ADDR) begin
      hit_pc = 1'b1;
    end else if (paddr == IRQ_ENABLE_ADDR) begin
      hit_ie = 1'b1;
    end else if (paddr == MODE_STATUS_ADDR) begin
      hit_st = 1'b1;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(hit_pc || hit_ie || hit_st);
  assign wr_en   = psel && penable && pwrite && pstrb[0];
  assign rd_en   = psel && penable && !pwrite;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_pc) begin
        prdata <= {24'h00_0000, power_control_q};
      end else if (hit_ie) begin
        prdata <= {24'h00_0000, irq_enable_q};
      end else if (hit_st) begin
        prdata <= {30'h0000_0000, mode_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // wake and reset sources
  // ---------------------------------------------------------------
  // source and global enable
  assign wake_irq = irq_enable_q[GLOBAL_IE_BIT] &&
                    |(irq_pending & irq_enable_q[NUM_IRQ-1:0]);

  reset_filter #(
    .HOLD_CLKS (HOLD_CLKS)
  ) u_reset_filter (
    .sys_clk       (sys_clk),
    .rstn          (rstn),
    .ext_reset_req (ext_reset_req),
    .reset_taken   (ext_taken)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lvr_q <= 1'b0;
    end else begin
      lvr_q <= low_voltage_detect && !power_control_q[LVR_DIS_BIT];
    end
  end

  assign int_reset = lvr_q || watchdog_reset;
  assign any_reset = int_reset || ext_taken;
  assign low_voltage_reset = lvr_q;

  // ---------------------------------------------------------------
  // power control and interrupt enable registers
  // ---------------------------------------------------------------
  // hardware clear of idle wins only against the sticky request; a
  // write in the same cycle that sets idle again still takes effect
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      power_control_q <= POWER_CONTROL_RST;
    end else if (any_reset) begin
      power_control_q <= POWER_CONTROL_RST;
    end else if (wr_en && hit_pc) begin
      power_control_q <= pwdata[7:0];
    end else if (mode_q == MODE_IDLE && wake_irq) begin
      power_control_q[IDLE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_enable_q <= IRQ_ENABLE_RST;
    end else if (any_reset) begin
      irq_enable_q <= IRQ_ENABLE_RST;
    end else if (wr_en && hit_ie) begin
      irq_enable_q <= pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN: begin
        if (power_control_q[PDOWN_BIT]) begin
          mode_d = MODE_PDOWN;
        end else if (power_control_q[IDLE_BIT]) begin
          mode_d = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        // internal or qualified external reset restarts after a delay
        if (int_reset || ext_taken) begin
          mode_d = MODE_RESTART;
        end else if (power_control_q[PDOWN_BIT]) begin
          mode_d = MODE_PDOWN;
        end else if (!power_control_q[IDLE_BIT] || wake_irq) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_PDOWN: begin
        if (any_reset) begin
          mode_d = MODE_RESTART;
        end
      end
      MODE_RESTART: begin
        if (restart_done) begin
          mode_d = MODE_RUN;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  assign restart_start = (mode_q != MODE_RESTART) &&
                         (mode_d == MODE_RESTART);

  cycle_counter #(
    .WIDTH (8)
  ) u_restart_cnt (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .start    (restart_start),
    .load_val (8'(RESTART_CLKS)),
    .busy     (restart_busy),
    .done     (restart_done)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      core_reset_q <= 1'b1;
    end else begin
      core_reset_q <= any_reset || (mode_d == MODE_RESTART);
    end
  end

  // ---------------------------------------------------------------
  // clock gating, reset, mode and peripheral config outputs
  // ---------------------------------------------------------------
  // idle: cpu halted, peripherals run
  assign cpu_clk_en    = (mode_q == MODE_RUN) && !core_reset_q;
  assign periph_clk_en = (mode_q != MODE_PDOWN);
  assign osc_enable    = (mode_q != MODE_PDOWN);
  assign core_reset    = core_reset_q;
  assign mode          = mode_q;

  assign periph_cfg.uart1_baud_double  = power_control_q[U1_DBL_BIT];
  assign periph_cfg.uart2_baud_double  = power_control_q[U2_DBL_BIT];
  assign periph_cfg.low_voltage_reset_disable =
    power_control_q[LVR_DIS_BIT];
  assign periph_cfg.adc_irq_enable     = power_control_q[ADC_IRQ_BIT];
  assign periph_cfg.uart2_rx_clock_select = power_control_q[U2_RXCLK_BIT];
  assign periph_cfg.uart2_tx_clock_select = power_control_q[U2_TXCLK_BIT];

endmodule : power_saving_mode_control

// *** rtl/pwr_mode_pkg.sv ***
// package: power control register layout, timing counts and shared types
package pwr_mode_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  // printed offset 0x87 is not a multiple of four: index, byte = 4*index
  localparam logic [7:0]  POWER_CONTROL_IDX  = 8'h87;
  localparam logic [11:0] POWER_CONTROL_ADDR = {2'h0, POWER_CONTROL_IDX, 2'h0};
  localparam logic [11:0] IRQ_ENABLE_ADDR    = 12'h300;
  localparam logic [11:0] MODE_STATUS_ADDR   = 12'h304;
  localparam logic [7:0]  POWER_CONTROL_RST  = 8'h00;
  localparam logic [7:0]  IRQ_ENABLE_RST     = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int IDLE_BIT     = 0;
  localparam int PDOWN_BIT    = 1;
  localparam int U2_TXCLK_BIT = 2;
  localparam int U2_RXCLK_BIT = 3;
  localparam int ADC_IRQ_BIT  = 4;
  localparam int LVR_DIS_BIT  = 5;
  localparam int U2_DBL_BIT   = 6;
  localparam int U1_DBL_BIT   = 7;
  localparam int GLOBAL_IE_BIT = 7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PER_MCYCLE    = 12;
  localparam int RESTART_MCYCLES   = 3;
  localparam int RESTART_CLKS      = RESTART_MCYCLES * CLK_PER_MCYCLE;
  localparam int EXT_RST_MCYCLES   = 2;
  localparam int EXT_RST_CLKS      = EXT_RST_MCYCLES * CLK_PER_MCYCLE;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN,
    MODE_RESTART
  } pwr_mode_t;

  typedef struct packed {
    logic uart1_baud_double;
    logic uart2_baud_double;
    logic low_voltage_reset_disable;
    logic adc_irq_enable;
    logic uart2_rx_clock_select;
    logic uart2_tx_clock_select;
  } periph_cfg_t;

endpackage : pwr_mode_pkg

// *** rtl/cycle_counter.sv ***
// module: loadable down counter that flags when its count runs out
`timescale 1ns/1ps
module cycle_counter
  import pwr_mode_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load_val,
  output logic                  busy,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_q;
  logic             busy_q;

  initial begin
    if (WIDTH < 2) $error("cycle_counter width too small");
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= load_val;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - WIDTH'(1);
      if (cnt_q == WIDTH'(1)) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign busy = busy_q;
  assign done = busy_q && (cnt_q == WIDTH'(1));

endmodule : cycle_counter

// *** rtl/reset_filter.sv ***
// module: qualifies the external reset input by a minimum hold time
`timescale 1ns/1ps
module reset_filter
  import pwr_mode_pkg::*;
#(
  parameter int HOLD_CLKS = EXT_RST_CLKS
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic ext_reset_req,
  output logic      reset_taken
);

  localparam int W = $clog2(HOLD_CLKS + 1);

  logic [W-1:0] hold_q;
  logic         taken_q;

  initial begin
    if (HOLD_CLKS < 1) $error("reset_filter hold count must be positive");
  end

  // short glitches never reach the full hold count
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= '0;
    end else if (!ext_reset_req) begin
      hold_q <= '0;
    end else if (hold_q != W'(HOLD_CLKS)) begin
      hold_q <= hold_q + W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= ext_reset_req && (hold_q == W'(HOLD_CLKS - 1));
    end
  end

  assign reset_taken = taken_q;

endmodule : reset_filter

// *** dv/pwr_mode_props.sv ***
// checker: port-level properties of the power-mode controller
`timescale 1ns/1ps
module pwr_mode_props
  import pwr_mode_pkg::*;
#(
  parameter int NUM_IRQ = 7
) (
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [3:0]         pstrb,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic               ext_reset_req,
  input wire logic               low_voltage_detect,
  input wire logic               watchdog_reset,
  input wire logic               cpu_clk_en,
  input wire logic               periph_clk_en,
  input wire logic               osc_enable,
  input wire logic               core_reset,
  input wire logic               low_voltage_reset,
  input wire periph_cfg_t        periph_cfg,
  input wire pwr_mode_t          mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic       wr;
  logic       src;
  logic       wake;
  logic       pc_wr;
  logic [7:0] ie_q;
  logic [5:0] rcnt_q;

  assign wr = psel & penable & pwrite & pstrb[0];
  assign pc_wr = wr & (paddr == POWER_CONTROL_ADDR);
  assign src = ext_reset_req | low_voltage_detect | watchdog_reset |
               core_reset | low_voltage_reset;
  assign wake = ie_q[7] & (|(irq_pending & ie_q[NUM_IRQ-1:0]));

  // shadow of the enable register; dropped on restart to stay conservative
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ie_q <= 8'h00;
    else if (mode == MODE_RESTART) ie_q <= 8'h00;
    else if (wr && paddr == IRQ_ENABLE_ADDR) ie_q <= pwdata[7:0];
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rcnt_q <= 6'h00;
    else if (mode == MODE_RESTART) rcnt_q <= rcnt_q + 6'h01;
    else rcnt_q <= 6'h00;
  end

  a_mode_entry: assert property (pc_wr && pwdata[1:0] != 2'h0 &&
    mode == MODE_RUN && !src |-> ##2
    mode == ($past(pwdata[1], 2) ? MODE_PDOWN : MODE_IDLE))
    else $error("mode not entered after request");
  a_idle_clocks: assert property (mode == MODE_IDLE |->
    periph_clk_en && osc_enable && !cpu_clk_en)
    else $error("idle clock enables wrong");
  a_pdown_clocks: assert property (mode == MODE_PDOWN |->
    !osc_enable && !periph_clk_en && !cpu_clk_en)
    else $error("power-down clocks still on");
  a_idle_wake: assert property (mode == MODE_IDLE && wake &&
    !src |=> mode == MODE_RUN)
    else $error("enabled interrupt did not end idle");
  a_idle_hold: assert property (mode == MODE_IDLE && !wake &&
    !src && !psel |=> mode != MODE_RUN)
    else $error("idle left without enabled interrupt");
  a_pdown_exit: assert property (mode == MODE_PDOWN ##1
    mode != MODE_PDOWN |-> mode == MODE_RESTART)
    else $error("power-down left without reset");
  a_pdown_keep: assert property (mode == MODE_PDOWN ##1
    mode == MODE_PDOWN |-> $stable(periph_cfg))
    else $error("config changed in power-down");
  a_restart_len: assert property (mode == MODE_RESTART ##1
    mode == MODE_RUN |-> rcnt_q == 6'(RESTART_CLKS))
    else $error("restart length wrong");
  a_lvr_follow: assert property (low_voltage_reset ==
    $past(low_voltage_detect && !periph_cfg.low_voltage_reset_disable))
    else $error("low-voltage reset mismatch");
  a_cfg_write: assert property (pc_wr && !src |=>
    periph_cfg == $past(pwdata[7:2]))
    else $error("config bits not updated");

  cover property (mode == MODE_IDLE ##1 mode == MODE_RUN);
  cover property (mode == MODE_PDOWN ##1 mode == MODE_RESTART);
  cover property (low_voltage_reset);
endmodule : pwr_mode_props

bind power_saving_mode_control pwr_mode_props #(
  .NUM_IRQ (NUM_IRQ)
) i_props (
  .sys_clk            (sys_clk),
  .rstn               (rstn),
  .psel               (psel),
  .penable            (penable),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .pwdata             (pwdata),
  .pstrb              (pstrb),
  .irq_pending        (irq_pending),
  .ext_reset_req      (ext_reset_req),
  .low_voltage_detect (low_voltage_detect),
  .watchdog_reset     (watchdog_reset),
  .cpu_clk_en         (cpu_clk_en),
  .periph_clk_en      (periph_clk_en),
  .osc_enable         (osc_enable),
  .core_reset         (core_reset),
  .low_voltage_reset  (low_voltage_reset),
  .periph_cfg         (periph_cfg),
  .mode               (mode)
);

// *** dv/far_side_model.sv ***
// far side: interrupt sources, reset inputs and supply monitor
`timescale 1ns/1ps
module far_side_model
  import pwr_mode_pkg::*;
#(
  parameter int NUM_IRQ   = 7,
  parameter int HOLD_CLKS = 2
) (
  input  wire logic        sys_clk,
  output logic [NUM_IRQ-1:0] irq_pending,
  output logic             ext_reset_req,
  output logic             low_voltage_detect,
  output logic             watchdog_reset
);
  initial begin
    irq_pending = '0;
    ext_reset_req = 1'b0;
    low_voltage_detect = 1'b0;
    watchdog_reset = 1'b0;
  end

  task automatic set_irq(input logic [NUM_IRQ-1:0] v);
    @(posedge sys_clk);
    irq_pending <= v;
  endtask : set_irq

  task automatic set_lvd(input logic v);
    @(posedge sys_clk);
    low_voltage_detect <= v;
  endtask : set_lvd

  task automatic hold_ext();
    @(posedge sys_clk);
    ext_reset_req <= 1'b1;
    repeat (HOLD_CLKS) @(posedge sys_clk);
    ext_reset_req <= 1'b0;
  endtask : hold_ext

  task automatic pulse_wdog();
    @(posedge sys_clk);
    watchdog_reset <= 1'b1;
    @(posedge sys_clk);
    watchdog_reset <= 1'b0;
  endtask : pulse_wdog
endmodule : far_side_model

// *** dv/tb_top.sv ***
// testbench: power-mode controller scenarios over apb
`timescale 1ns/1ps
module tb_top
  import pwr_mode_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [6:0]  irq_pending;
  logic        ext_reset_req, low_voltage_detect, watchdog_reset;
  logic        cpu_clk_en, periph_clk_en, osc_enable;
  logic        core_reset, low_voltage_reset;
  periph_cfg_t periph_cfg;
  pwr_mode_t   mode;
  int          mismatches, num_checks, cyc;

  power_saving_mode_control #(.NUM_IRQ(7), .HOLD_CLKS(2)) i_dut (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .pready             (pready),
    .prdata             (prdata),
    .pslverr            (pslverr),
    .irq_pending        (irq_pending),
    .ext_reset_req      (ext_reset_req),
    .low_voltage_detect (low_voltage_detect),
    .watchdog_reset     (watchdog_reset),
    .cpu_clk_en         (cpu_clk_en),
    .periph_clk_en      (periph_clk_en),
    .osc_enable         (osc_enable),
    .core_reset         (core_reset),
    .low_voltage_reset  (low_voltage_reset),
    .periph_cfg         (periph_cfg),
    .mode               (mode)
  );
  far_side_model #(.NUM_IRQ(7), .HOLD_CLKS(2)) i_far (
    .sys_clk            (sys_clk),
    .irq_pending        (irq_pending),
    .ext_reset_req      (ext_reset_req),
    .low_voltage_detect (low_voltage_detect),
    .watchdog_reset     (watchdog_reset)
  );

  always #2.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic wait_mode(input pwr_mode_t m);
    for (int i = 0; i < 100 && mode !== m; i++) @(negedge sys_clk);
    chk(32'(mode), 32'(m));
  endtask : wait_mode

  task automatic t_regs();
    apb(1'b0, POWER_CONTROL_ADDR, 32'h0);
    chk(rd, 32'(POWER_CONTROL_RST));
    apb(1'b0, MODE_STATUS_ADDR, 32'h0);
    chk(rd, 32'(MODE_RUN));
    // low byte strobe off: the write must be dropped
    pstrb <= 4'hE;
    apb(1'b1, POWER_CONTROL_ADDR, 32'hFC);
    pstrb <= 4'hF;
    apb(1'b0, POWER_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
    for (int b = 2; b < 8; b++) begin
      apb(1'b1, POWER_CONTROL_ADDR, 32'h1 << b);
      chk(32'(periph_cfg), 32'h1 << (b - 2));
      apb(1'b0, POWER_CONTROL_ADDR, 32'h0);
      chk(rd, 32'h1 << b);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
  endtask : t_regs

  task automatic t_lvr();
    apb(1'b1, POWER_CONTROL_ADDR, 32'h20);
    i_far.set_lvd(1'b1);
    repeat (3) @(negedge sys_clk);
    chk(32'(low_voltage_reset), 32'h0);
    i_far.set_lvd(1'b0);
    apb(1'b1, POWER_CONTROL_ADDR, 32'h0);
    i_far.set_lvd(1'b1);
    repeat (3) @(negedge sys_clk);
    chk(32'(low_voltage_reset), 32'h1);
    i_far.set_lvd(1'b0);
    repeat (60) @(posedge sys_clk);
  endtask : t_lvr

  task automatic t_idle();
    apb(1'b1, IRQ_ENABLE_ADDR, 32'h81);
    apb(1'b1, POWER_CONTROL_ADDR, 32'h1);
    wait_mode(MODE_IDLE);
    chk(32'({cpu_clk_en, periph_clk_en, osc_enable}), 32'h3);
    i_far.set_irq(7'h02);
    repeat (5) @(negedge sys_clk);
    chk(32'(mode), 32'(MODE_IDLE));
    i_far.set_irq(7'h03);
    wait_mode(MODE_RUN);
    i_far.set_irq(7'h00);
    apb(1'b0, POWER_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
  endtask : t_idle

  task automatic t_ext();
    apb(1'b1, IRQ_ENABLE_ADDR, 32'h01);
    apb(1'b1, POWER_CONTROL_ADDR, 32'hC1);
    wait_mode(MODE_IDLE);
    i_far.set_irq(7'h01);
    repeat (5) @(negedge sys_clk);
    chk(32'(mode), 32'(MODE_IDLE));
    i_far.hold_ext();
    wait_mode(MODE_RESTART);
    chk(32'(core_reset), 32'h1);
    wait_mode(MODE_RUN);
    i_far.set_irq(7'h00);
    apb(1'b0, POWER_CONTROL_ADDR, 32'h0);
    chk(rd, 32'h0);
  endtask : t_ext

  task automatic t_pdown();
    apb(1'b1, IRQ_ENABLE_ADDR, 32'h81);
    apb(1'b1, POWER_CONTROL_ADDR, 32'hC3);
    wait_mode(MODE_PDOWN);
    chk(32'({osc_enable, periph_clk_en}), 32'h0);
    i_far.set_irq(7'h01);
    repeat (20) @(negedge sys_clk);
    chk(32'(mode), 32'(MODE_PDOWN));
    chk(32'(periph_cfg), 32'h30);
    i_far.pulse_wdog();
    wait_mode(MODE_RUN);
    i_far.set_irq(7'h00);
  endtask : t_pdown

  task automatic end_sim();
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    rstn = 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_lvr();
    t_idle();
    t_ext();
    t_pdown();
    end_sim();
  end
endmodule : tb_top
